// ---- pkg/lmr_pkg.sv ----
// Constants and types shared by the logic, move and rotate execute block.
package lmr_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int FILE_DEPTH = 128;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    // Destination bit position and opcode values within a 14-bit instruction word.
    localparam int DEST_BIT = 7;
    localparam logic [13:0] OP_NO_OP = 14'h0000;
    localparam logic [13:0] OP_RETFI = 14'h0009;
    localparam logic [5:0] OP_STORE_HI = 6'h00;
    localparam logic [5:0] OP_OR_FILE = 6'h04;
    localparam logic [5:0] OP_MOVE_FILE = 6'h08;
    localparam logic [5:0] OP_ROT_LEFT = 6'h0d;
    localparam logic [5:0] OP_OR_LIT = 6'h38;
    localparam logic [3:0] OP_LOAD_LIT = 4'hc;

    typedef enum logic [2:0] {
        LMR_NO_OP = 3'b000,
        LMR_OR_LIT = 3'b001,
        LMR_LOAD_LIT = 3'b010,
        LMR_OR_FILE = 3'b011,
        LMR_STORE = 3'b100,
        LMR_MOVE = 3'b101,
        LMR_RETFI = 3'b110,
        LMR_ROT_LEFT = 3'b111
    } lmr_op_e;
endpackage : lmr_pkg

// ---- pkg/lmr_file_if.sv ----
// Interface between the execute core and its file register memory.
`timescale 1ns/100ps
interface lmr_file_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] rdata;
    modport core (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface : lmr_file_if

// ---- rtl/lmr_file_mem.sv ----
// File register memory with registered read data.
`timescale 1ns/100ps
module lmr_file_mem (
    input wire logic clk_i,
    lmr_file_if.mem bus
);
    logic [7:0] mem_ff [lmr_pkg::FILE_DEPTH];
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = mem_ff[bus.addr];
    end

    always_ff @(posedge clk_i)
    begin
        if (bus.we)
        begin
            mem_ff[bus.addr] <= bus.wdata;
        end
        rdata_ff <= nxt_rdata;
    end

    assign bus.rdata = rdata_ff;
endmodule : lmr_file_mem

// ---- rtl/lmr_execute.sv ----
// Two-phase executor for the logic, move and rotate instruction subset.
`timescale 1ns/100ps
// Operation
// - OR literal into work, update zero.
// - Load literal into work, flags unchanged.
// - OR work with file, update zero.
// - Store work to file, flags unchanged.
// - Move file to destination, update zero.
// - Destination bit zero work, one file.
// - Rotate file left through carry flag.
module lmr_execute (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [12:0] top_of_return_stack_i,
    output logic instr_ready_o,
    output logic [7:0] work_o,
    output logic zero_o,
    output logic carry_o,
    output logic [12:0] pc_o,
    output logic pc_load_o,
    output logic stack_pop_o,
    output logic global_interrupt_enable_o
);
    typedef enum logic [0:0] {
        LMR_IDLE = 1'b0,
        LMR_EXEC = 1'b1
    } lmr_state_e;

    lmr_file_if fbus ();

    lmr_file_mem u_mem (
        .clk_i(clk_i),
        .bus(fbus)
    );

    lmr_state_e state_ff, nxt_state;
    lmr_pkg::lmr_op_e op_ff, nxt_op;
    logic [7:0] lit_ff, nxt_lit;
    logic [6:0] addr_ff, nxt_addr;
    logic dest_ff, nxt_dest;
    logic [7:0] work_ff, nxt_work;
    logic zero_ff, nxt_zero;
    logic carry_ff, nxt_carry;
    logic int_enable_ff, nxt_int_enable;
    logic [12:0] pc_ff, nxt_pc;
    logic pc_load_ff, nxt_pc_load;
    lmr_pkg::lmr_op_e dec_op;
    logic [7:0] result;
    logic to_file;

    // Decode of the fixed encoding fields.
    always_comb
    begin
        dec_op = lmr_pkg::LMR_NO_OP;
        if (instr_i == lmr_pkg::OP_RETFI)
        begin
            dec_op = lmr_pkg::LMR_RETFI;
        end
        else if (instr_i[13:10] == lmr_pkg::OP_LOAD_LIT)
        begin
            // Low bits of the opcode are don't cares assembled as zero.
            dec_op = lmr_pkg::LMR_LOAD_LIT;
        end
        else if (instr_i[13:8] == lmr_pkg::OP_OR_LIT)
        begin
            dec_op = lmr_pkg::LMR_OR_LIT;
        end
        else if (instr_i[13:8] == lmr_pkg::OP_OR_FILE)
        begin
            dec_op = lmr_pkg::LMR_OR_FILE;
        end
        else if (instr_i[13:8] == lmr_pkg::OP_MOVE_FILE)
        begin
            dec_op = lmr_pkg::LMR_MOVE;
        end
        else if (instr_i[13:8] == lmr_pkg::OP_ROT_LEFT)
        begin
            dec_op = lmr_pkg::LMR_ROT_LEFT;
        end
        else if (instr_i[13:8] == lmr_pkg::OP_STORE_HI
                 && instr_i[lmr_pkg::DEST_BIT])
        begin
            dec_op = lmr_pkg::LMR_STORE;
        end
    end

    // The file operand arrives a cycle after the address, so every
    // instruction takes two cycles; this keeps the memory a plain RAM.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_lit = lit_ff;
        nxt_addr = addr_ff;
        nxt_dest = dest_ff;
        nxt_work = work_ff;
        nxt_zero = zero_ff;
        nxt_carry = carry_ff;
        nxt_int_enable = int_enable_ff;
        nxt_pc = pc_ff;
        nxt_pc_load = 1'b0;
        result = 8'h00;
        to_file = 1'b0;
        case (state_ff)
            LMR_IDLE:
            begin
                if (instr_valid_i)
                begin
                    nxt_state = LMR_EXEC;
                    nxt_op = dec_op;
                    nxt_lit = instr_i[7:0];
                    nxt_addr = instr_i[6:0];
                    nxt_dest = instr_i[lmr_pkg::DEST_BIT];
                end
            end
            LMR_EXEC:
            begin
                nxt_state = LMR_IDLE;
                case (op_ff)
                    lmr_pkg::LMR_OR_LIT:
                    begin
                        result = work_ff | lit_ff;
                        nxt_work = result;
                        nxt_zero = (result == 8'h00);
                    end
                    lmr_pkg::LMR_LOAD_LIT:
                    begin
                        nxt_work = lit_ff;
                    end
                    lmr_pkg::LMR_OR_FILE:
                    begin
                        result = work_ff | fbus.rdata;
                        nxt_zero = (result == 8'h00);
                        to_file = dest_ff;
                    end
                    lmr_pkg::LMR_STORE:
                    begin
                        result = work_ff;
                        to_file = 1'b1;
                    end
                    lmr_pkg::LMR_MOVE:
                    begin
                        result = fbus.rdata;
                        nxt_zero = (result == 8'h00);
                        to_file = dest_ff;
                    end
                    lmr_pkg::LMR_ROT_LEFT:
                    begin
                        result = {fbus.rdata[6:0], carry_ff};
                        nxt_carry = fbus.rdata[7];
                        to_file = dest_ff;
                    end
                    lmr_pkg::LMR_RETFI:
                    begin
                        nxt_pc = top_of_return_stack_i;
                        nxt_pc_load = 1'b1;
                        nxt_int_enable = 1'b1;
                    end
                    default:
                    begin
                        result = 8'h00;
                    end
                endcase
                if ((op_ff == lmr_pkg::LMR_OR_FILE
                     || op_ff == lmr_pkg::LMR_MOVE
                     || op_ff == lmr_pkg::LMR_ROT_LEFT) && !dest_ff)
                begin
                    nxt_work = result;
                end
            end
            default:
            begin
                nxt_state = LMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_ff <= LMR_IDLE;
            op_ff <= lmr_pkg::LMR_NO_OP;
            lit_ff <= 8'h00;
            addr_ff <= 7'h00;
            dest_ff <= 1'b0;
            work_ff <= lmr_pkg::WORK_RST;
            zero_ff <= 1'b0;
            carry_ff <= 1'b0;
            int_enable_ff <= 1'b0;
            pc_ff <= lmr_pkg::PC_RST;
            pc_load_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            lit_ff <= nxt_lit;
            addr_ff <= nxt_addr;
            dest_ff <= nxt_dest;
            work_ff <= nxt_work;
            zero_ff <= nxt_zero;
            carry_ff <= nxt_carry;
            int_enable_ff <= nxt_int_enable;
            pc_ff <= nxt_pc;
            pc_load_ff <= nxt_pc_load;
        end
    end

    // Address is presented in the accept cycle so the read data is ready.
    assign fbus.addr = (state_ff == LMR_IDLE) ? instr_i[6:0] : addr_ff;
    assign fbus.wdata = result;
    assign fbus.we = (state_ff == LMR_EXEC) && to_file;

    assign instr_ready_o = (state_ff == LMR_IDLE);
    assign work_o = work_ff;
    assign zero_o = zero_ff;
    assign carry_o = carry_ff;
    assign pc_o = pc_ff;
    assign pc_load_o = pc_load_ff;
    assign stack_pop_o = pc_load_ff;
    assign global_interrupt_enable_o = int_enable_ff;
endmodule : lmr_execute

// ---- verification/lmr_execute_sva.sv ----
// Port checks for the execute block.
`timescale 1ns/100ps
module lmr_execute_sva (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [12:0] top_of_return_stack_i,
    input wire logic instr_ready_o,
    input wire logic [7:0] work_o,
    input wire logic zero_o,
    input wire logic carry_o,
    input wire logic [12:0] pc_o,
    input wire logic pc_load_o,
    input wire logic stack_pop_o,
    input wire logic global_interrupt_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic take;
    assign take = instr_valid_i && instr_ready_o;
    sequence s_take(logic [5:0] op);
        take && instr_i[13:8] == op;
    endsequence
    a_busy_cycle: assert property (take |=> !instr_ready_o ##1 instr_ready_o)
        else $error("ready did not follow the two cycle pattern");
    a_or_literal: assert property (s_take(6'h38) |=> ##1
        work_o == ($past(work_o, 2) | $past(instr_i[7:0], 2))
        && zero_o == (work_o == 8'h00)) else $error("or literal wrong");
    a_load_literal: assert property (take && instr_i[13:10] == 4'hc
        |=> ##1 work_o == $past(instr_i[7:0], 2) && zero_o == $past(zero_o, 2))
        else $error("load literal wrong");
    a_store_keeps: assert property (s_take(6'h00) ##0 instr_i[7] |=> ##1
        zero_o == $past(zero_o, 2) && work_o == $past(work_o, 2))
        else $error("store changed state");
    a_move_zero: assert property (s_take(6'h08) ##0 !instr_i[7]
        |=> ##1 zero_o == (work_o == 8'h00)) else $error("move zero wrong");
    a_file_dest: assert property (s_take(6'h04) ##0 instr_i[7]
        |=> ##1 work_o == $past(work_o, 2)) else $error("work written");
    a_or_file_zero: assert property (s_take(6'h04) ##0 !instr_i[7]
        |=> ##1 zero_o == (work_o == 8'h00)) else $error("or file zero");
    a_rotate_in: assert property (s_take(6'h0d) ##0 !instr_i[7]
        |=> ##1 work_o[0] == $past(carry_o, 2)) else $error("rotate bit0");
    a_carry_cause: assert property (!$stable(carry_o) && $past(resetn_i)
        |-> $past(take && instr_i[13:8] == 6'h0d, 2))
        else $error("carry changed without rotate");
    a_return_op: assert property (take && instr_i == 14'h0009 |=> ##1
        pc_load_o && stack_pop_o && global_interrupt_enable_o
        && pc_o == $past(top_of_return_stack_i) && zero_o == $past(zero_o, 2))
        else $error("return effects wrong");
    a_pulse_cause: assert property (pc_load_o || stack_pop_o
        |-> $past(take && instr_i == 14'h0009, 2)) else $error("stray pulse");
    a_enable_sticky: assert property (global_interrupt_enable_o
        |=> global_interrupt_enable_o) else $error("enable dropped");
endmodule : lmr_execute_sva

bind lmr_execute lmr_execute_sva u_sva (.*);

// ---- verification/tb.sv ----
// Self-checking bench for the execute block.
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic [12:0] top_of_return_stack_i = 13'h0000;
    logic instr_ready_o, zero_o, carry_o, pc_load_o, stack_pop_o;
    logic global_interrupt_enable_o;
    logic [7:0] work_o;
    logic [12:0] pc_o;
    int errors = 0;
    int checks = 0;
    int w = 0, z = 0, c = 0, g = 0, a = 0, p = 0;
    int m [128];
    always #20 clk_i = ~clk_i;
    lmr_execute dut (.*);
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    // Each call ends at a falling edge with a junk literal load still
    // offered, so the next call must follow at once or the junk load is accepted.
    task automatic exe(input int op, input int f, input int d, input int k);
        logic [13:0] ins;
        logic [12:0] t;
        int r;
        case (op)
            0: ins = 14'h0000;
            1: ins = 14'h0009;
            2: ins = {7'h01, 7'(f)};
            3: ins = {6'h04, 1'(d), 7'(f)};
            4: ins = {6'h08, 1'(d), 7'(f)};
            5: ins = {6'h0d, 1'(d), 7'(f)};
            6: ins = {6'h38, 8'(k)};
            default: ins = {4'hc, 2'($urandom), 8'(k)};
        endcase
        instr_valid_i = 1'b1;
        instr_i = ins;
        @(posedge clk_i);
        @(negedge clk_i);
        t = 13'($urandom);
        top_of_return_stack_i = t;
        instr_i = {6'h30, 8'($urandom)};
        @(posedge clk_i);
        @(negedge clk_i);
        r = w;
        case (op)
            1:
            begin
                g = 1;
                p = t;
            end
            2: m[f] = w;
            3: r = w | m[f];
            4: r = m[f];
            5:
            begin
                r = ((m[f] << 1) | c) & 255;
                c = m[f] >> 7;
            end
            6: w = w | k;
            7: w = k;
            default: ;
        endcase
        if (op >= 3 && op <= 5 && d == 1) m[f] = r;
        if (op >= 3 && op <= 5 && d == 0) w = r;
        if (op == 6) z = (w == 0);
        if (op == 3 || op == 4) z = (r == 0);
        chk({5'h00, work_o}, 13'(w));
        chk({12'h000, zero_o}, 13'(z));
        chk({12'h000, carry_o}, 13'(c));
        chk({12'h000, global_interrupt_enable_o}, 13'(g));
        chk({12'h000, pc_load_o}, 13'(op == 1));
        chk({12'h000, stack_pop_o}, 13'(op == 1));
        chk(pc_o, 13'(p));
    endtask : exe
    initial
    begin
        #(40 * 900);
        errors++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h6862b80a));
        repeat (3) @(negedge clk_i);
        resetn_i = 1'b1;
        exe(0, 0, 0, 0);
        for (int i = 0; i < 8; i++)
        begin
            exe(7, 0, 0, $urandom_range(0, 255));
            exe(2, (i == 7) ? 127 : i, 0, 0);
        end
        // A zero value tested in place must raise the zero flag.
        exe(7, 0, 0, 0);
        exe(2, 5, 0, 0);
        exe(4, 5, 1, 0);
        exe(6, 0, 0, 0);
        for (int i = 0; i < 150; i++)
        begin
            a = $urandom_range(0, 7);
            exe($urandom_range(0, 7), (a == 7) ? 127 : a,
                $urandom_range(0, 1), $urandom_range(0, 255));
        end
        instr_valid_i = 1'b0;
        close_out();
    end
endmodule : tb
